// ===== hdl/ssidl_pkg.sv
// constants for the subsystem identification eeprom loader
package ssidl_pkg;

  // configuration header location and value after reset
  localparam logic [7:0]  SSIDL_IDENT_OFFSET = 8'h20;
  localparam logic [31:0] SSIDL_IDENT_RESET  = 32'h0000_0000;

  // eeprom addressing
  localparam logic [6:0] SSIDL_EE_ADDR7   = 7'h50;
  localparam logic [7:0] SSIDL_CTRL_WR    = {SSIDL_EE_ADDR7, 1'b0};
  localparam logic [7:0] SSIDL_CTRL_RD    = {SSIDL_EE_ADDR7, 1'b1};
  localparam logic [7:0] SSIDL_FIRST_BYTE = 8'hfc;

  // operation sequence positions and the ack bit slot
  localparam logic [3:0] SSIDL_OP_RESTART = 4'h3;
  localparam logic [3:0] SSIDL_OP_RD0     = 4'h5;
  localparam logic [3:0] SSIDL_OP_RDLAST  = 4'h8;
  localparam logic [3:0] SSIDL_OP_STOP    = 4'h9;
  localparam logic [3:0] SSIDL_ACK_BIT    = 4'h8;

  // link timing: quarter bit period, least time rounded up
  localparam int SSIDL_I2C_RATE_KHZ  = 100;
  localparam int SSIDL_LINK_PER_PS   = 30000;
  localparam int SSIDL_BIT_TIME_NS   = 1000000 / SSIDL_I2C_RATE_KHZ;
  localparam int SSIDL_QTR_CYC       =
    (SSIDL_BIT_TIME_NS * 250 + SSIDL_LINK_PER_PS - 1) / SSIDL_LINK_PER_PS;

  // expected upload duration on the system clock
  localparam int SSIDL_SYS_PER_NS    = 100;
  localparam int SSIDL_UPLOAD_US     = 660;
  localparam int SSIDL_UPLOAD_CYC    = SSIDL_UPLOAD_US * 1000 / SSIDL_SYS_PER_NS;

  // link sequencer states
  typedef enum logic [4:0] {
    SSIDL_ST_IDLE  = 5'b00001,
    SSIDL_ST_START = 5'b00010,
    SSIDL_ST_BIT   = 5'b00100,
    SSIDL_ST_STOP  = 5'b01000,
    SSIDL_ST_DONE  = 5'b10000
  } ssidl_state_e;

endpackage

// ===== hdl/ssidl_loader.sv
// eeprom upload of the subsystem identification word with config access
`timescale 1ns/10ps
`default_nettype none
module ssidl_loader
  import ssidl_pkg::*;
#(
  parameter int UPLOAD_TIME_CYC = SSIDL_UPLOAD_CYC, // expected upload, system cycles
  parameter int QTR_CYC         = SSIDL_QTR_CYC     // quarter bit, link cycles
)
(
  input  wire logic        clock_i,              // system clock
  input  wire logic        sys_rst_i,            // async reset, high
  input  wire logic        link_clk_i,           // i2c engine clock
  input  wire logic        cfg_req_i,            // config access strobe
  input  wire logic        cfg_wr_i,             // access is a write
  input  wire logic [7:0]  cfg_addr_i,           // header byte offset
  input  wire logic [3:0]  cfg_be_i,             // byte enables
  input  wire logic [31:0] cfg_wdata_i,          // write data
  input  wire logic        ident_write_enable_i, // device control bit
  output logic             cfg_ack_o,            // access completed
  output logic             cfg_retry_o,          // access terminated with retry
  output logic [31:0]      cfg_rdata_o,          // read data
  output logic             upload_busy_o,        // word not yet loaded
  input  wire logic        scl_i,                // clock line level
  output logic             scl_o,                // clock line drive value
  output logic             scl_oe_o,             // clock line drive enable
  input  wire logic        sda_i,                // data line level
  output logic             sda_o,                // data line drive value
  output logic             sda_oe_o,             // data line drive enable
  output logic             i2c_owned_o           // engine holds the i2c circuit
);

  localparam logic [15:0] LIMIT_CYC = 16'(2 * UPLOAD_TIME_CYC);
  localparam logic [15:0] QTR_LAST  = 16'(QTR_CYC - 1);

  // ---------------- system clock domain ----------------
  logic        start_reg;       // upload request level
  logic        done_meta_reg;   // done synchroniser, first stage
  logic        done_sync_reg;   // done synchroniser, second stage
  logic        loaded_reg;      // word has been updated
  logic [15:0] wait_cnt_reg;    // guard against a hung upload
  logic [31:0] ident_word_reg;  // identification word
  logic [31:0] ident_word_next; // its next value
  logic [31:0] wr_merge;        // word with enabled lanes replaced
  logic        cfg_ack_reg;     // answer flops
  logic        cfg_retry_reg;
  logic [31:0] cfg_rdata_reg;
  logic [31:0] link_word_reg;   // link result, stable once done
  logic        i2c_done_reg;    // link upload finished, level

  wire cfg_hit   = cfg_req_i && (cfg_addr_i == SSIDL_IDENT_OFFSET);
  wire timeout   = (wait_cnt_reg == LIMIT_CYC);
  wire load_now  = !loaded_reg && (done_sync_reg || timeout);
  wire wr_allow  = cfg_hit && cfg_wr_i && loaded_reg && ident_write_enable_i;

  // per lane write merge
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      assign wr_merge[8*g +: 8] = cfg_be_i[g] ? cfg_wdata_i[8*g +: 8]
                                              : ident_word_reg[8*g +: 8];
    end
  endgenerate

  // a timeout without a result leaves the default word
  assign ident_word_next = load_now ? (done_sync_reg ? link_word_reg : SSIDL_IDENT_RESET)
                         : wr_allow ? wr_merge
                         : ident_word_reg;

  // upload request and done crossing
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      start_reg     <= 1'b0;
      done_meta_reg <= 1'b0;
      done_sync_reg <= 1'b0;
    end
    else
    begin
      start_reg     <= 1'b1;
      done_meta_reg <= i2c_done_reg;
      done_sync_reg <= done_meta_reg;
    end
  end

  // load state and word
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      loaded_reg     <= 1'b0;
      wait_cnt_reg   <= 16'h0000;
      ident_word_reg <= SSIDL_IDENT_RESET;
    end
    else
    begin
      if (load_now)
        loaded_reg <= 1'b1;
      if (!loaded_reg && !timeout)
        wait_cnt_reg <= wait_cnt_reg + 16'h0001;
      ident_word_reg <= ident_word_next;
    end
  end

  // config answer: retry until loaded, else complete
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cfg_ack_reg   <= 1'b0;
      cfg_retry_reg <= 1'b0;
      cfg_rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      cfg_ack_reg   <= cfg_hit && loaded_reg;
      cfg_retry_reg <= cfg_hit && !loaded_reg;
      cfg_rdata_reg <= (cfg_hit && !cfg_wr_i && loaded_reg) ? ident_word_reg : 32'h0000_0000;
    end
  end

  assign cfg_ack_o     = cfg_ack_reg;
  assign cfg_retry_o   = cfg_retry_reg;
  assign cfg_rdata_o   = cfg_rdata_reg;
  logic busy_reg; // mirrors not loaded, as a flop
  assign upload_busy_o = busy_reg;

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      busy_reg <= 1'b1;
    else
      busy_reg <= !(loaded_reg || load_now);
  end

  // ---------------- link clock domain ----------------
  logic         lrst_meta_reg;  // reset release synchroniser
  logic         lrst_reg;
  logic         start_meta_reg; // request synchroniser
  logic         start_sync_reg;
  logic         sda_meta_reg;   // data line synchroniser
  logic         sda_sync_reg;
  logic         scl_meta_reg;   // clock line synchroniser
  logic         scl_sync_reg;
  ssidl_state_e state_reg;      // sequencer state
  ssidl_state_e state_next;
  logic [3:0]   op_reg;         // position in the upload sequence
  logic [3:0]   bit_reg;        // bit in byte, 8 is the ack slot
  logic [1:0]   qph_reg;        // quarter of the bit period
  logic [15:0]  qcnt_reg;       // quarter period counter
  logic         scl_oe_reg;
  logic         sda_oe_reg;
  logic         owned_reg;

  wire tick        = (qcnt_reg == QTR_LAST);
  wire op_is_read  = (op_reg >= SSIDL_OP_RD0) && (op_reg <= SSIDL_OP_RDLAST);
  wire last_read   = (op_reg == SSIDL_OP_RDLAST);
  wire ack_slot    = (bit_reg == SSIDL_ACK_BIT);
  wire [2:0] bidx  = 3'd7 - bit_reg[2:0];
  // control bytes and start address of the upload
  wire [7:0] tx_byte = (op_reg == 4'h1) ? SSIDL_CTRL_WR
                     : (op_reg == 4'h2) ? SSIDL_FIRST_BYTE
                     : SSIDL_CTRL_RD;
  // data line drive while shifting a bit
  wire bit_drive   = op_is_read ? (ack_slot && !last_read)
                   : (!ack_slot && !tx_byte[bidx]);
  wire nack_seen   = (state_reg == SSIDL_ST_BIT) && !op_is_read && ack_slot
                   && (qph_reg == 2'd2) && tick && sda_sync_reg;
  wire byte_end    = (state_reg == SSIDL_ST_BIT) && ack_slot && (qph_reg == 2'd3) && tick;
  wire [3:0] op_nx = op_reg + 4'h1;
  wire scl_oe_next = (state_reg == SSIDL_ST_START || state_reg == SSIDL_ST_BIT
                     || state_reg == SSIDL_ST_STOP) && (qph_reg == 2'd0 || qph_reg == 2'd3);
  wire sda_oe_next = (state_reg == SSIDL_ST_START) ? (qph_reg >= 2'd2)
                   : (state_reg == SSIDL_ST_STOP)  ? (qph_reg < 2'd2)
                   : (state_reg == SSIDL_ST_BIT)   ? bit_drive
                   : 1'b0;

  // sequencer next state
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      SSIDL_ST_IDLE:
        if (start_sync_reg)
          state_next = SSIDL_ST_START;
      SSIDL_ST_START:
        if (tick && qph_reg == 2'd3)
          state_next = SSIDL_ST_BIT;
      SSIDL_ST_BIT:
        if (nack_seen)
          state_next = SSIDL_ST_STOP;
        else if (byte_end)
          state_next = (op_nx == SSIDL_OP_STOP) ? SSIDL_ST_STOP
                     : (op_nx == SSIDL_OP_RESTART) ? SSIDL_ST_START
                     : SSIDL_ST_BIT;
      SSIDL_ST_STOP:
        if (tick && qph_reg == 2'd3)
          state_next = SSIDL_ST_DONE;
      SSIDL_ST_DONE:
        state_next = SSIDL_ST_DONE;
    endcase
  end

  // link reset release and input synchronisers
  always_ff @(posedge link_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      lrst_meta_reg  <= 1'b1;
      lrst_reg       <= 1'b1;
      start_meta_reg <= 1'b0;
      start_sync_reg <= 1'b0;
      {sda_meta_reg, sda_sync_reg, scl_meta_reg, scl_sync_reg} <= 4'hf;
    end
    else
    begin
      lrst_meta_reg  <= 1'b0;
      lrst_reg       <= lrst_meta_reg;
      start_meta_reg <= start_reg;
      start_sync_reg <= start_meta_reg;
      sda_meta_reg   <= sda_i;
      sda_sync_reg   <= sda_meta_reg;
      scl_meta_reg   <= scl_i;
      scl_sync_reg   <= scl_meta_reg;
    end
  end

  // quarter timing and bit position
  always_ff @(posedge link_clk_i or posedge lrst_reg)
  begin
    if (lrst_reg)
    begin
      state_reg <= SSIDL_ST_IDLE;
      qcnt_reg  <= 16'h0000;
      qph_reg   <= 2'd0;
      bit_reg   <= 4'h0;
      op_reg    <= 4'h0;
    end
    else
    begin
      state_reg <= state_next;
      qcnt_reg  <= (tick || state_reg == SSIDL_ST_IDLE) ? 16'h0000 : qcnt_reg + 16'h0001;
      if (tick)
        qph_reg <= qph_reg + 2'd1;
      if (state_reg == SSIDL_ST_START && tick && qph_reg == 2'd3)
        op_reg <= op_nx;
      else if (nack_seen)
        op_reg <= SSIDL_OP_STOP;
      else if (byte_end)
        op_reg <= op_nx;
      if (byte_end || nack_seen)
        bit_reg <= 4'h0;
      else if (state_reg == SSIDL_ST_BIT && tick && qph_reg == 2'd3)
        bit_reg <= bit_reg + 4'h1;
    end
  end

  // received word, pins and ownership
  always_ff @(posedge link_clk_i or posedge lrst_reg)
  begin
    if (lrst_reg)
    begin
      link_word_reg <= 32'h0000_0000;
      scl_oe_reg    <= 1'b0;
      sda_oe_reg    <= 1'b0;
      owned_reg     <= 1'b0;
      i2c_done_reg  <= 1'b0;
    end
    else
    begin
      if (nack_seen)
        link_word_reg <= 32'h0000_0000;
      else if (op_is_read && state_reg == SSIDL_ST_BIT && !ack_slot
               && qph_reg == 2'd2 && tick)
        link_word_reg <= {link_word_reg[30:0], sda_sync_reg};
      scl_oe_reg   <= scl_oe_next;
      sda_oe_reg   <= sda_oe_next;
      owned_reg    <= (state_next != SSIDL_ST_IDLE) && (state_next != SSIDL_ST_DONE);
      i2c_done_reg <= (state_reg == SSIDL_ST_DONE);
    end
  end

  assign scl_o       = 1'b0;
  assign sda_o       = 1'b0;
  assign scl_oe_o    = scl_oe_reg;
  assign sda_oe_o    = sda_oe_reg;
  assign i2c_owned_o = owned_reg;

  // ---------------- checks ----------------
  chk_retry_before_load: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (cfg_hit && !loaded_reg) |=> (cfg_retry_o && !cfg_ack_o))
    else $error("access before load not retried");

  chk_word_default_zero: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    !loaded_reg |-> (ident_word_reg == SSIDL_IDENT_RESET))
    else $error("word not zero before load");

  chk_write_gated: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (loaded_reg && cfg_hit && cfg_wr_i && !ident_write_enable_i) |=> $stable(ident_word_reg))
    else $error("write landed without enable");

  chk_write_lands: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (loaded_reg && cfg_hit && cfg_wr_i && ident_write_enable_i && cfg_be_i == 4'hf)
    |=> (ident_word_reg == $past(cfg_wdata_i)))
    else $error("enabled write lost");

  chk_upload_bound: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    timeout |=> loaded_reg)
    else $error("upload not ended at limit");

  chk_nack_abort: assert property (
    @(posedge link_clk_i) disable iff (lrst_reg)
    nack_seen |=> (state_reg == SSIDL_ST_STOP && link_word_reg == 32'h0000_0000))
    else $error("target nack did not abort");

  chk_master_ack: assert property (
    @(posedge link_clk_i) disable iff (lrst_reg)
    (state_reg == SSIDL_ST_BIT && op_is_read && ack_slot && qph_reg == 2'd1)
    |-> (sda_oe_o == !last_read))
    else $error("wrong master acknowledge");

  chk_restart_cond: assert property (
    @(posedge link_clk_i) disable iff (lrst_reg)
    (state_reg == SSIDL_ST_START && qph_reg == 2'd2 && tick) |=> sda_oe_o && !scl_oe_o)
    else $error("start condition malformed");

  chk_bus_released: assert property (
    @(posedge link_clk_i) disable iff (lrst_reg)
    (state_reg == SSIDL_ST_DONE) |=> (!scl_oe_o && !sda_oe_o && !i2c_owned_o))
    else $error("bus held after upload");

endmodule // ssidl_loader
`default_nettype wire

// ===== tb/ssidl_eeprom_model.sv
// behavioural serial eeprom answering the identification upload
`timescale 1ns/10ps
`default_nettype none
module ssidl_eeprom_model #(
  parameter logic [31:0] WORD = 32'h3c5a_96e1 // contents of bytes 0xfc..0xff, 0xfc first
)
(
  input  wire logic scl_i,     // clock line level
  input  wire logic sda_i,     // data line level
  input  wire logic present_i, // low models an empty socket
  output var  logic sda_oe_o   // high pulls the data line low
);
  int         bc = -1;      // bit count in the byte, -1 between frames
  logic       rd = 1'b0;    // read direction selected
  logic       first = 1'b0; // next byte is the control byte
  logic       mack = 1'b0;  // master asked for another byte
  logic       dat = 1'b0;   // a data byte was just sent
  logic [7:0] sh = 8'h00;   // byte being received
  logic [7:0] ptr = 8'h00;  // byte address pointer
  logic [7:0] rx_q[$];      // bytes received from the master
  logic       ack_q[$];     // master acknowledges after data bytes
  wire  [7:0] cur = WORD[8*(3-ptr[1:0]) +: 8]; // byte at the pointer

  initial sda_oe_o = 1'b0;

  // start or repeated start: data falls while clock is high
  always @(negedge sda_i)
    if (scl_i === 1'b1)
    begin
      bc = 0;
      rd = 1'b0;
      first = 1'b1;
      sda_oe_o = 1'b0;
    end

  // stop: data rises while clock is high, line released
  always @(posedge sda_i)
    if (scl_i === 1'b1)
    begin
      bc = -1;
      sda_oe_o = 1'b0;
    end

  // sample bits and the master acknowledge on the rising clock
  always @(posedge scl_i)
    if (bc >= 0)
    begin
      if (bc < 8)
        sh = {sh[6:0], sda_i};
      else if (rd)
      begin
        mack = ~sda_i;
        if (dat)
          ack_q.push_back(mack);
      end
      bc++;
    end

  // drive acknowledge and read data while the clock is low
  always @(negedge scl_i)
    if (bc >= 0)
    begin
      if (bc == 9)
      begin
        bc = 0;
        dat = 1'b0;
      end
      if (rd && bc == 8)
      begin
        sda_oe_o = 1'b0; // master owns the acknowledge slot
        ptr++;           // sequential read advances the address
        dat = 1'b1;
      end
      else if (rd)
        sda_oe_o = mack & ~cur[7-bc]; // data msb first, released after a nack
      else if (bc == 8)
      begin
        rx_q.push_back(sh);
        sda_oe_o = present_i & (~first | (sh[7:1] == 7'h50));
        rd = first & sh[0] & present_i;
        mack = 1'b1;
        if (!first)
          ptr = sh;
        first = 1'b0;
      end
      else
        sda_oe_o = 1'b0;
    end
endmodule // ssidl_eeprom_model
`default_nettype wire

// ===== tb/ssidl_loader_test.sv
// testbench for the identification word loader
`timescale 1ns/10ps
`default_nettype none
module ssidl_loader_test;
  import ssidl_pkg::*;
  localparam logic [31:0] WORD = 32'h3c5a_96e1; // eeprom contents, 0xfc first
  logic        clock_i = 1'b0;    // system clock
  logic        link_clk = 1'b0;   // link clock
  logic        sys_rst_i = 1'b1;  // reset
  logic        cfg_req = 1'b0;    // config strobe
  logic        cfg_wr = 1'b0;     // write select
  logic [7:0]  cfg_addr = 8'h00;  // header offset
  logic [3:0]  cfg_be = 4'h0;     // byte enables
  logic [31:0] cfg_wdata = 32'h0; // write data
  logic        wr_en = 1'b0;      // identification write enable
  logic        present = 1'b1;    // eeprom fitted
  logic        link_run = 1'b1;   // link clock runs
  logic        ack, rty, busy, owned;          // design answers
  logic [31:0] rdata;                          // read data
  logic        scl_o, scl_oe, sda_o, sda_oe, ee_oe; // line drivers
  wire         scl_w = scl_oe ? scl_o : 1'b1;  // pulled-up clock line
  wire         sda_w = (sda_oe ? sda_o : 1'b1) & ~ee_oe; // wired-and data line
  int          num_errors = 0;    // mismatches
  int          compares = 0;      // comparisons made
  int          cyc = 0;           // elapsed cycles
  logic        a, r;              // sampled answer
  logic [31:0] d;                 // sampled read data

  // clocks, unrelated in phase
  always #50 clock_i = ~clock_i;
  always #15 link_clk = ~link_clk;
  wire         link_clk_g = link_clk & link_run; // stopped to force the load timeout

  ssidl_loader #(.UPLOAD_TIME_CYC(2000), .QTR_CYC(4)) dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_g),
    .cfg_req_i(cfg_req), .cfg_wr_i(cfg_wr), .cfg_addr_i(cfg_addr), .cfg_be_i(cfg_be),
    .cfg_wdata_i(cfg_wdata), .ident_write_enable_i(wr_en), .cfg_ack_o(ack),
    .cfg_retry_o(rty), .cfg_rdata_o(rdata), .upload_busy_o(busy), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .i2c_owned_o(owned));

  ssidl_eeprom_model #(.WORD(WORD)) ee (
    .scl_i(scl_w), .sda_i(sda_w), .present_i(present), .sda_oe_o(ee_oe));

  task automatic finish_test();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // compare and report one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one config access, answer taken from the two cycles after the request
  task automatic cfg(input logic wr, input logic [7:0] ad, input logic [3:0] be,
                     input logic [31:0] wd);
    @(posedge clock_i);
    cfg_req <= 1'b1;
    cfg_wr <= wr;
    cfg_addr <= ad;
    cfg_be <= be;
    cfg_wdata <= wd;
    @(posedge clock_i);
    cfg_req <= 1'b0;
    #1;
    {a, r, d} = {ack, rty, rdata};
    @(posedge clock_i);
    #1;
    {a, r, d} = {a | ack, r | rty, d | rdata};
  endtask

  task automatic do_reset();
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    repeat (20) @(posedge clock_i);
    sys_rst_i <= 1'b0;
  endtask

  // wait for the upload to end, then ten cycles, and check that the bus is handed back
  task automatic wait_load();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 5000)
    begin
      @(posedge clock_i);
      n++;
    end
    chk(busy, 1'b0);
    repeat (10) @(posedge clock_i);
    chk({owned, scl_oe, sda_oe}, 3'b000);
  endtask

  // cycle ceiling against a hang
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      finish_test();
    end
  end

  // main sequence
  initial
  begin
    do_reset();
    cfg(1'b0, 8'h20, 4'hf, 32'h0);
    chk({a, r}, 2'b01);
    cfg(1'b1, 8'h20, 4'hf, 32'hffff_ffff);
    chk({a, r}, 2'b01);
    chk(busy, 1'b1);
    wait_load();
    cfg(1'b0, 8'h20, 4'hf, 32'h0);
    chk({a, r}, 2'b10);
    chk(d, WORD);
    chk(ee.rx_q.size(), 32'd3);
    chk({ee.rx_q[0], ee.rx_q[1], ee.rx_q[2]}, 24'ha0fca1);
    chk(ee.ack_q.size(), 32'd4);
    chk({ee.ack_q[0], ee.ack_q[1], ee.ack_q[2], ee.ack_q[3]}, 4'he);
    cfg(1'b0, 8'h24, 4'hf, 32'h0);
    chk({a, r}, 2'b00);
    cfg(1'b1, 8'h20, 4'hf, 32'h1234_5678);
    chk({a, r}, 2'b10);
    cfg(1'b0, 8'h20, 4'hf, 32'h0);
    chk(d, WORD);
    wr_en <= 1'b1;
    cfg(1'b1, 8'h20, 4'hf, 32'h0f1e_2d3c);
    cfg(1'b1, 8'h20, 4'b0011, 32'ha5a5_a5a5);
    cfg(1'b1, 8'h20, 4'b1000, 32'h7700_0000);
    wr_en <= 1'b0;
    cfg(1'b1, 8'h20, 4'hf, 32'h0);
    cfg(1'b0, 8'h20, 4'hf, 32'h0);
    chk(d, {8'h77, 8'h1e, 16'ha5a5});
    ee.rx_q.delete();
    present <= 1'b0;
    do_reset();
    wait_load();
    cfg(1'b0, 8'h20, 4'hf, 32'h0);
    chk({a, r}, 2'b10);
    chk(d, 32'h0);
    chk(ee.rx_q.size(), 32'd1);
    chk(ee.rx_q[0], 32'h0000_00a0);
    // link clock held: the load must end by the time limit with the default word
    link_run <= 1'b0;
    do_reset();
    repeat (1000) @(posedge clock_i);
    chk(busy, 1'b1);
    wait_load();
    cfg(1'b0, 8'h20, 4'hf, 32'h0);
    chk({a, r}, 2'b10);
    chk(d, 32'h0);
    finish_test();
  end
endmodule // ssidl_loader_test
`default_nettype wire
